// [eso_pkg.sv]
// Constants, register map and types of the emergency stop sequencer.
// Assumes a 50 MHz pclk and an APB master with 32-bit data.
`default_nettype none
package eso_pkg;
  // ********************************************************************
  // Clock and time base
  // ********************************************************************
  localparam int CLK_HZ        = 50_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
  localparam int DIAG_PULSE_US = 500;
  localparam int DIAG_PULSE_CYC = (CLK_HZ / 1_000_000) * DIAG_PULSE_US;
  localparam logic [15:0] DIAG_PERIOD_MS = 16'h0064;
  localparam logic [15:0] DIAG_HALF_MS   = 16'h0032;
  localparam logic [15:0] FB_MUTE_MS     = 16'h000A;
  // ********************************************************************
  // Register offsets
  // ********************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_TO_DLY  = 8'h04;
  localparam logic [7:0] OFS_ZS_DLY  = 8'h08;
  localparam logic [7:0] OFS_ZS_SPD  = 8'h0C;
  localparam logic [7:0] OFS_BRK_SPD = 8'h10;
  localparam logic [7:0] OFS_BRK_OFS = 8'h14;
  localparam logic [7:0] OFS_RAMP_T  = 8'h18;
  localparam logic [7:0] OFS_SCALE   = 8'h1C;
  localparam logic [7:0] OFS_WIN     = 8'h20;
  localparam logic [7:0] OFS_TMIN    = 8'h24;
  localparam logic [7:0] OFS_TMAX    = 8'h28;
  localparam logic [7:0] OFS_STATUS  = 8'h2C;
  // ********************************************************************
  // Control bit positions
  // ********************************************************************
  localparam int CB_TYPE    = 0;
  localparam int CB_METHOD  = 1;
  localparam int CB_ENC     = 2;
  localparam int CB_FBACT   = 3;
  localparam int CB_FBKIND  = 4;
  localparam int CB_REDUND  = 5;
  localparam int CB_DIAG_A  = 6;
  localparam int CB_DIAG_B  = 7;
  localparam int CB_AUTOACK = 8;
  localparam int CB_TOBRK   = 9;
  localparam int CB_ACK     = 10;
  localparam int CTRL_W     = 10;
  // ********************************************************************
  // Values after reset
  // ********************************************************************
  localparam logic [9:0]  CTRL_RST    = 10'h100;
  localparam logic [15:0] TO_DLY_RST  = 16'h07D0;
  localparam logic [15:0] ZS_DLY_RST  = 16'h0000;
  localparam logic [15:0] ZS_SPD_RST  = 16'h005A;
  localparam logic [15:0] BRK_SPD_RST = 16'h0000;
  localparam logic [15:0] BRK_OFS_RST = 16'h0000;
  localparam logic [15:0] RAMP_T_RST  = 16'h03E8;
  localparam logic [15:0] SCALE_RST   = 16'h05DC;
  localparam logic [15:0] WIN_RST     = 16'h0064;
  localparam logic [15:0] TMIN_RST    = 16'h01F4;
  localparam logic [15:0] TMAX_RST    = 16'h05DC;
  // ********************************************************************
  // Sequencer states
  // ********************************************************************
  typedef enum logic [2:0] {
    ESO_IDLE, ESO_RAMP, ESO_ZDELAY, ESO_BDELAY, ESO_BOFS, ESO_STOPPED
  } eso_state_e;
endpackage
`default_nettype wire

// [eso_sequencer.sv]
// Emergency stop sequencer with ramp supervision and brake control.
// Assumes speed_rpm comes from logic on pclk; contacts and brake
// feedback are asynchronous pins.
// Function
// R1: Emergency ramp uses ramp set zero registers, never ramp set one.
// R2: Setting selects elapsed-time or ramp-envelope supervision.
// R3: Time supervision removes torque after the request delay.
// R4: Speed at zero threshold completes the stop, encoder picks threshold.
// R5: Zero-speed delay before torque off; zero removes torque at once.
// R6: Nonzero brake speed engages brake and torque off below it.
// R7: Offset between brake engagement and torque off; zero is same cycle.
// R8: Delay after brake speed crossing before brake and torque off.
// R9: Brake feedback mismatch removes torque when that reaction is set.
// R10: NC feedback kind expects inverse of the relay output.
// R11: Redundant brake output pair with optional diagnostic test pulses.
// R12: Brake speed enable also enables it for the controlled stop.
// R13: Plain torque-off brake enable stays a separate setting.
// R14: Supervision limit violation during the ramp removes torque.
// R15: Nominal slope is scaling speed to zero in the ramp time.
// R16: Initial tolerance window before envelope checking applies.
// R17: Deceleration faster than minimum ramp time slope is a violation.
// R18: Deceleration slower than maximum ramp time slope is a violation.
// R19: Stop switch supplies a redundant two-channel request.
// R20: Outputs show emergency stop active and emergency stop completed.
// R21: Shared ramp set is tuned for the tightest supervision window.
// R22: Automatic acknowledge clears completed torque off without ack.
// R23: Thresholds compare speed magnitude, both directions alike.
`default_nettype none
module eso_sequencer #(
  parameter int CYCLES_PER_MS   = eso_pkg::CYCLES_PER_MS,
  parameter int DIAG_PULSE_CYC  = eso_pkg::DIAG_PULSE_CYC
) (
  // APB slave.
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [eso_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Emergency contacts, speed and brake feedback.
  input  wire logic                       estop_a_n,
  input  wire logic                       estop_b_n,
  input  wire logic signed [15:0]         speed_rpm,
  input  wire logic                       relay_one_feedback_input,
  // Power stage, brake relays and indicators.
  output logic                            torque_off,
  output logic                            brake_rel_a,
  output logic                            brake_rel_b,
  output logic                            emergency_active_output,
  output logic                            emergency_completed_output,
  output logic                            decel_request,
  output logic      [15:0]                ramp_speed_ref,
  output logic                            ctrl_stop_brake_enable,
  output logic                            torque_off_brake_enable
);
  import eso_pkg::*;

  // ********************************************************************
  // Elaboration checks
  // ********************************************************************
  if (CYCLES_PER_MS < 2 || DIAG_PULSE_CYC < 1) begin : g_bad
    $error("eso_sequencer: time base parameters out of range");
  end

  localparam logic [31:0] CPM_M1 = 32'(CYCLES_PER_MS - 1);
  localparam logic [31:0] DPC_M1 = 32'(DIAG_PULSE_CYC - 1);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [1:0]    sa;
    logic [1:0]    sb;
    logic [1:0]    sf;
    logic [9:0]    ctrl;
    logic          ack;
    logic [15:0]   to_dly;
    logic [15:0]   zs_dly;
    logic [15:0]   zs_noenc;
    logic [15:0]   zs_enc;
    logic [15:0]   brk_spd;
    logic [15:0]   brk_ofs;
    logic [15:0]   ramp_t;
    logic [15:0]   scale;
    logic [15:0]   win;
    logic [15:0]   tmin;
    logic [15:0]   tmax;
    eso_state_e    st;
    logic [31:0]   pre;
    logic [15:0]   t_ms;
    logic [15:0]   s_ms;
    logic [15:0]   v0;
    logic [15:0]   vref;
    logic [31:0]   acc;
    logic          brk_on;
    logic          viol;
    logic          fbf;
    logic [15:0]   mm_ms;
    logic [15:0]   pms;
    logic [31:0]   pw;
    logic          pa;
    logic          pb;
    logic [31:0]   rdata;
    logic          rerr;
    logic          oa;
    logic          ob;
  } eso_state_s;

  eso_state_s q;
  eso_state_s d;

  logic        tick;
  logic        req;
  logic [15:0] spd;
  logic [15:0] zs_thr;
  logic [15:0] dv;
  logic [31:0] fast_l;
  logic [31:0] slow_l;
  logic [31:0] lin_t;
  logic [31:0] lin_w;
  logic        env_bad;
  logic        rel;
  logic        fb_exp;
  logic        mism;
  logic        wr;
  logic        rd;
  logic [31:0] rv;
  logic        rbad;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    d = q;
    tick = (q.pre == CPM_M1);
    // R19 two channel request
    req = !q.sa[1] || !q.sb[1];
    // R23 speed magnitude
    spd = speed_rpm[15] ? 16'(-speed_rpm) : 16'(speed_rpm);
    // R4 encoder selects threshold
    zs_thr = q.ctrl[CB_ENC] ? q.zs_enc : q.zs_noenc;
    dv = (q.v0 > spd) ? 16'(q.v0 - spd) : 16'h0000;
    fast_l = 32'(dv) * 32'(q.tmin);
    slow_l = 32'(dv) * 32'(q.tmax);
    lin_t = 32'(q.scale) * 32'(q.t_ms);
    lin_w = 32'(q.scale) * 32'(16'(q.t_ms - q.win));
    env_bad = 1'b0;
    // R16 initial window
    if (q.t_ms >= q.win) begin
      // R17 too fast
      if (fast_l > lin_t) begin
        env_bad = 1'b1;
      end
      // R18 too slow
      if (slow_l < lin_w) begin
        env_bad = 1'b1;
      end
    end
    rel = !q.brk_on;
    // R10 NC inverse feedback
    fb_exp = q.ctrl[CB_FBKIND] ? !rel : rel;
    mism = (q.sf[1] != fb_exp);

    d.sa = {q.sa[0], estop_a_n};
    d.sb = {q.sb[0], estop_b_n};
    d.sf = {q.sf[0], relay_one_feedback_input};
    d.ack = 1'b0;
    d.pre = tick ? 32'h0000_0000 : 32'(q.pre + 32'h0000_0001);
    if (tick && q.s_ms != 16'hFFFF) begin
      d.s_ms = 16'(q.s_ms + 16'h0001);
    end
    if (tick && q.t_ms != 16'hFFFF && q.st != ESO_IDLE) begin
      d.t_ms = 16'(q.t_ms + 16'h0001);
    end

    // R9 feedback mismatch filter
    if (!mism) begin
      d.mm_ms = 16'h0000;
    end else if (tick && q.mm_ms != 16'hFFFF) begin
      d.mm_ms = 16'(q.mm_ms + 16'h0001);
    end
    if (mism && q.mm_ms >= FB_MUTE_MS) begin
      d.fbf = 1'b1;
    end

    case (q.st)
      ESO_IDLE: begin
        d.t_ms = 16'h0000;
        d.brk_on = 1'b0;
        if (req) begin
          d.v0 = spd;
          d.vref = spd;
          d.acc = 32'h0000_0000;
          d.st = q.ctrl[CB_TYPE] ? ESO_RAMP : ESO_STOPPED;
        end
      end
      ESO_RAMP: begin
        // R15 nominal slope reference
        if (q.ramp_t == 16'h0000) begin
          d.vref = 16'h0000;
        end else if (q.acc >= 32'(q.ramp_t) && q.vref != 16'h0000) begin
          d.acc = 32'(q.acc - 32'(q.ramp_t)
                  + (tick ? 32'(q.scale) : 32'h0000_0000));
          d.vref = 16'(q.vref - 16'h0001);
        end else if (tick) begin
          d.acc = 32'(q.acc + 32'(q.scale));
        end
        // R2 supervision method
        if (q.ctrl[CB_METHOD]) begin
          // R14 envelope violation
          if (env_bad) begin
            d.viol = 1'b1;
            d.st = ESO_STOPPED;
          end
        end else if (q.t_ms >= q.to_dly) begin
          // R3 delay elapsed
          d.viol = (spd > zs_thr);
          d.st = ESO_STOPPED;
        end
        if (d.st == ESO_RAMP) begin
          // R6 brake speed crossed
          if (q.brk_spd != 16'h0000 && spd < q.brk_spd) begin
            // R8 zero delay skips wait
            if (q.zs_dly == 16'h0000) begin
              d.brk_on = 1'b1;
              d.st = (q.brk_ofs == 16'h0000) ? ESO_STOPPED : ESO_BOFS;
            end else begin
              d.st = ESO_BDELAY;
            end
          end else if (spd <= zs_thr) begin
            // R5 immediate when zero
            d.st = (q.zs_dly == 16'h0000) ? ESO_STOPPED : ESO_ZDELAY;
          end
        end
      end
      ESO_ZDELAY: begin
        // R5 zero speed delay
        if (q.s_ms >= q.zs_dly) begin
          d.st = ESO_STOPPED;
        end
      end
      ESO_BDELAY: begin
        // R8 brake delay
        if (q.s_ms >= q.zs_dly) begin
          d.brk_on = 1'b1;
          d.st = (q.brk_ofs == 16'h0000) ? ESO_STOPPED : ESO_BOFS;
        end
      end
      ESO_BOFS: begin
        // R7 brake to torque offset
        if (q.s_ms >= q.brk_ofs) begin
          d.st = ESO_STOPPED;
        end
      end
      ESO_STOPPED: begin
        // R22 automatic acknowledge
        if (!req && !mism && (q.ctrl[CB_AUTOACK] || q.ack)) begin
          d.st = ESO_IDLE;
          d.viol = 1'b0;
          d.fbf = 1'b0;
          d.brk_on = 1'b0;
        end
      end
      default: begin
        d.st = ESO_STOPPED;
      end
    endcase

    // R9 feedback fault torque off
    if (d.fbf && q.ctrl[CB_FBACT] && q.st != ESO_STOPPED) begin
      d.st = ESO_STOPPED;
    end
    if (d.st != q.st) begin
      d.s_ms = 16'h0000;
    end

    // R11 diagnostic pulse timing
    if (tick) begin
      d.pms = (q.pms == 16'(DIAG_PERIOD_MS - 16'h0001)) ? 16'h0000
            : 16'(q.pms + 16'h0001);
      if (q.pms == 16'h0000) begin
        d.pa = 1'b1;
        d.pw = 32'h0000_0000;
      end
      if (q.pms == DIAG_HALF_MS) begin
        d.pb = 1'b1;
        d.pw = 32'h0000_0000;
      end
    end else if (q.pa || q.pb) begin
      if (q.pw == DPC_M1) begin
        d.pa = 1'b0;
        d.pb = 1'b0;
      end else begin
        d.pw = 32'(q.pw + 32'h0000_0001);
      end
    end
    // R11 redundant pulsed outputs
    d.oa = !d.brk_on && !(q.ctrl[CB_DIAG_A] && q.pa);
    d.ob = q.ctrl[CB_REDUND] && !d.brk_on
         && !(q.ctrl[CB_DIAG_B] && q.pb);

    // Register read decode and write.
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    rbad = 1'b0;
    case (paddr)
      OFS_CTRL:    rv = {22'h000000, q.ctrl};
      OFS_TO_DLY:  rv = {16'h0000, q.to_dly};
      OFS_ZS_DLY:  rv = {16'h0000, q.zs_dly};
      OFS_ZS_SPD:  rv = {q.zs_enc, q.zs_noenc};
      OFS_BRK_SPD: rv = {16'h0000, q.brk_spd};
      OFS_BRK_OFS: rv = {16'h0000, q.brk_ofs};
      OFS_RAMP_T:  rv = {16'h0000, q.ramp_t};
      OFS_SCALE:   rv = {16'h0000, q.scale};
      OFS_WIN:     rv = {16'h0000, q.win};
      OFS_TMIN:    rv = {16'h0000, q.tmin};
      OFS_TMAX:    rv = {16'h0000, q.tmax};
      OFS_STATUS:  rv = {q.vref, 7'h00, mism, q.fbf, q.viol, q.brk_on,
                         req, 1'b0, 3'(q.st)};
      default: begin
        rv = 32'h0000_0000;
        rbad = 1'b1;
      end
    endcase
    if (psel && !penable) begin
      d.rdata = rd ? rv : 32'h0000_0000;
      d.rerr = rbad;
    end
    if (wr) begin
      case (paddr)
        OFS_CTRL: begin
          d.ctrl = pwdata[CTRL_W-1:0];
          d.ack = pwdata[CB_ACK];
        end
        OFS_TO_DLY:  d.to_dly = pwdata[15:0];
        OFS_ZS_DLY:  d.zs_dly = pwdata[15:0];
        OFS_ZS_SPD: begin
          d.zs_noenc = pwdata[15:0];
          d.zs_enc = pwdata[31:16];
        end
        OFS_BRK_SPD: d.brk_spd = pwdata[15:0];
        OFS_BRK_OFS: d.brk_ofs = pwdata[15:0];
        // R1 ramp set zero
        OFS_RAMP_T:  d.ramp_t = pwdata[15:0];
        OFS_SCALE:   d.scale = pwdata[15:0];
        OFS_WIN:     d.win = pwdata[15:0];
        OFS_TMIN:    d.tmin = pwdata[15:0];
        OFS_TMAX:    d.tmax = pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.sa <= 2'h3;
      q.sb <= 2'h3;
      q.ctrl <= CTRL_RST;
      q.to_dly <= TO_DLY_RST;
      q.zs_dly <= ZS_DLY_RST;
      q.zs_noenc <= ZS_SPD_RST;
      q.zs_enc <= ZS_SPD_RST;
      q.brk_spd <= BRK_SPD_RST;
      q.brk_ofs <= BRK_OFS_RST;
      q.ramp_t <= RAMP_T_RST;
      q.scale <= SCALE_RST;
      q.win <= WIN_RST;
      q.tmin <= TMIN_RST;
      q.tmax <= TMAX_RST;
      q.st <= ESO_IDLE;
    end else begin
      q <= d;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && q.rerr;
  assign torque_off = (q.st == ESO_STOPPED);
  assign brake_rel_a = q.oa;
  assign brake_rel_b = q.ob;
  // R20 active and completed
  assign emergency_active_output = (q.st != ESO_IDLE);
  assign emergency_completed_output = (q.st == ESO_STOPPED);
  assign decel_request = (q.st == ESO_RAMP);
  assign ramp_speed_ref = q.vref;
  // R12 controlled stop brake
  assign ctrl_stop_brake_enable = (q.brk_spd != 16'h0000);
  // R13 separate torque-off brake
  assign torque_off_brake_enable = q.ctrl[CB_TOBRK];
endmodule
`default_nettype wire

// [eso_checker.sv]
// Port checker for the emergency stop sequencer.
// Assumes it is bound to eso_sequencer and sees only its ports.
`default_nettype none
module eso_checker
  import eso_pkg::*;
(
  // Clock, reset and bus.
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [eso_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  // Contacts and sequencer outputs.
  input wire logic                       estop_a_n,
  input wire logic                       torque_off,
  input wire logic                       emergency_active_output,
  input wire logic                       emergency_completed_output,
  input wire logic                       decel_request,
  input wire logic                       ctrl_stop_brake_enable,
  input wire logic                       torque_off_brake_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Properties
  // ****************************************
  wire logic wr_en;
  wire logic spd_nz;
  assign wr_en  = psel && penable && pwrite;
  assign spd_nz = |pwdata[15:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_done_act;
    emergency_completed_output |-> emergency_active_output;
  endproperty
  a_done_act: assert property (p_done_act)
    else $error("completed without active");
  property p_req;
    $fell(estop_a_n) && !emergency_active_output
      |-> ##[1:4] emergency_active_output;
  endproperty
  a_req: assert property (p_req)
    else $error("request not taken in time");
  property p_hold;
    emergency_completed_output && !estop_a_n |=> emergency_completed_output;
  endproperty
  a_hold: assert property (p_hold)
    else $error("completed cleared while requested");
  property p_dec;
    decel_request |-> emergency_active_output && !torque_off
      && !emergency_completed_output;
  endproperty
  a_dec: assert property (p_dec)
    else $error("ramp outside active stop");
  property p_done_to;
    emergency_completed_output |-> torque_off;
  endproperty
  a_done_to: assert property (p_done_to)
    else $error("completed with torque on");
  property p_idle_to;
    !emergency_active_output |-> !torque_off;
  endproperty
  a_idle_to: assert property (p_idle_to)
    else $error("torque off while idle");
  property p_cse;
    wr_en && paddr == OFS_BRK_SPD |=> ctrl_stop_brake_enable == $past(spd_nz);
  endproperty
  a_cse: assert property (p_cse)
    else $error("controlled stop brake enable wrong");
  property p_tbe;
    wr_en && paddr == OFS_CTRL |=> torque_off_brake_enable == $past(pwdata[9]);
  endproperty
  a_tbe: assert property (p_tbe)
    else $error("torque off brake enable wrong");
  c_ramp: cover property ($rose(decel_request));
  c_done: cover property ($rose(emergency_completed_output));
  c_cut:  cover property (decel_request ##1 torque_off);
endmodule
`default_nettype wire

// [eso_plant.sv]
// Model of the stop contacts, the motor speed and the brake contact.
// Assumes the bench commands button, speed profile and contact faults.
`default_nettype none
module eso_plant (
  // Clock, reset and bench commands.
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               press,
  input  wire logic               spd_load,
  input  wire logic signed [15:0] spd_init,
  input  wire logic signed [15:0] spd_step,
  input  wire logic               fb_nc,
  input  wire logic               fb_bad,
  // Sequencer outputs.
  input  wire logic               brake_rel_a,
  input  wire logic               decel_request,
  input  wire logic               torque_off,
  // Plant outputs.
  output logic                    estop_a_n,
  output logic                    estop_b_n,
  output logic signed [15:0]      speed_rpm,
  output logic                    fb_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  assign estop_a_n = !press;
  assign estop_b_n = !press;
  assign fb_pin = brake_rel_a ^ fb_nc ^ fb_bad;
  // Speed falls by one step a cycle while ramping or coasting.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_rpm <= 16'sh0000;
    end else if (spd_load) begin
      speed_rpm <= spd_init;
    end else if (decel_request || torque_off) begin
      if (speed_rpm > spd_step) begin
        speed_rpm <= speed_rpm - spd_step;
      end else if (speed_rpm < -spd_step) begin
        speed_rpm <= speed_rpm + spd_step;
      end else begin
        speed_rpm <= 16'sh0000;
      end
    end
  end
endmodule
`default_nettype wire

// [tb_emergency_stop_ramp_brake_sequencer.sv]
// Self-checking bench of the emergency stop sequencer.
// Assumes eso_pkg, eso_sequencer, eso_plant and eso_checker.
`default_nettype none
module tb_emergency_stop_ramp_brake_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import eso_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, pready, slv;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, q;
  logic               ea_n, eb_n, fb, tq, bra, brb, act, done, dec;
  logic               cse, tbe, press, sld, nc, bad, se;
  logic signed [15:0] spd, sinit, sstep;
  logic [15:0]        rref;
  int                 err_count, n_tests, n;
  localparam logic [7:0] RA [12] = '{OFS_CTRL, OFS_TO_DLY, OFS_ZS_DLY,
    OFS_ZS_SPD, OFS_BRK_SPD, OFS_BRK_OFS, OFS_RAMP_T, OFS_SCALE, OFS_WIN,
    OFS_TMIN, OFS_TMAX, 8'h30};
  localparam logic [31:0] RV [12] = '{32'h00000100, 32'h000007D0, 32'h0,
    32'h005A005A, 32'h0, 32'h0, 32'h000003E8, 32'h000005DC, 32'h00000064,
    32'h000001F4, 32'h000005DC, 32'h0};
  localparam int STP [3] = '{0, 2, 1};
  localparam int LO [3] = '{980, 980, 2880};
  localparam int HI [3] = '{1150, 1150, 2960};
  eso_sequencer #(.CYCLES_PER_MS(10), .DIAG_PULSE_CYC(3)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(slv), .estop_a_n(ea_n), .estop_b_n(eb_n),
    .speed_rpm(spd), .relay_one_feedback_input(fb), .torque_off(tq),
    .brake_rel_a(bra), .brake_rel_b(brb), .emergency_active_output(act),
    .emergency_completed_output(done), .decel_request(dec),
    .ramp_speed_ref(rref), .ctrl_stop_brake_enable(cse),
    .torque_off_brake_enable(tbe));
  eso_plant i_plant (.pclk(pclk), .presetn(presetn), .press(press),
    .spd_load(sld), .spd_init(sinit), .spd_step(sstep), .fb_nc(nc),
    .fb_bad(bad), .brake_rel_a(bra), .decel_request(dec), .torque_off(tq),
    .estop_a_n(ea_n), .estop_b_n(eb_n), .speed_rpm(spd), .fb_pin(fb));
  always #10 pclk = ~pclk;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    se = slv;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      chk("pready", pready, 1'b1);
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return act;
      1: return done;
      2: return !act;
      3: return tq || !bra;
      default: return !bra;
    endcase
  endfunction
  task automatic wait_on(input int s, input int lim);
    n = 0;
    while (sig(s) !== 1'b1) begin
      @(negedge pclk);
      n++;
      if (n > lim) begin
        chk("wait", s, 32'hFFFFFFFF);
        stop_test();
      end
    end
  endtask
  task automatic push(input logic v);
    @(posedge pclk);
    press <= v;
  endtask
  task automatic load(input logic signed [15:0] v, s);
    @(posedge pclk);
    sld <= 1'b1;
    sinit <= v;
    sstep <= s;
    @(posedge pclk);
    sld <= 1'b0;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {pclk, presetn, psel, penable, pwrite, press, sld, nc, bad} = '0;
    paddr = '0;
    pwdata = '0;
    sinit = '0;
    sstep = '0;
    err_count = 0;
    n_tests = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, RA[i], 32'h0);
      chk("reg", q, RV[i]);
      chk("slverr", se, i == 11);
    end
    for (int aa = 1; aa >= 0; aa--) begin
      wr(OFS_CTRL, aa ? 32'h00000100 : 32'h00000000);
      push(1'b1);
      wait_on(0, 10);
      chk("dec", dec, 1'b0);
      wait_on(1, 10);
      chk("tq", tq, 1'b1);
      push(1'b0);
      repeat (20) @(negedge pclk);
      chk("done", done, aa == 0);
      if (aa == 0) wr(OFS_CTRL, 32'h00000400);
      wait_on(2, 20);
    end
    wr(OFS_CTRL, 32'h00000101);
    wr(OFS_TO_DLY, 32'h00000005);
    load(16'sd3000, 16'sd0);
    push(1'b1);
    wait_on(1, 200);
    chk("tdly", n >= 40 && n <= 65, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("tviol", q[6], 1'b1);
    push(1'b0);
    wait_on(2, 50);
    wr(OFS_TO_DLY, 32'h000007D0);
    wr(OFS_TMIN, 32'h00000064);
    wr(OFS_TMAX, 32'h000003E8);
    wr(OFS_CTRL, 32'h00000103);
    for (int i = 0; i < 3; i++) begin
      load(i == 1 ? -16'sd3000 : 16'sd3000, 16'(STP[i]));
      push(1'b1);
      wait_on(1, 4000);
      chk("when", n >= LO[i] && n <= HI[i], 1'b1);
      chk("tq", tq, 1'b1);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("viol", q[6], i != 2);
      push(1'b0);
      wait_on(2, 50);
    end
    @(posedge pclk);
    nc <= 1'b1;
    wr(OFS_CTRL, 32'h00000139);
    wr(OFS_BRK_SPD, 32'h000000F0);
    @(negedge pclk);
    chk("en", {cse, tbe, brb}, 3'b101);
    load(16'sd400, 16'sd1);
    push(1'b1);
    wait_on(3, 400);
    chk("brk", {tq, bra, brb}, 3'b100);
    chk("bwhen", n >= 155 && n <= 185, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("fbf", q[7], 1'b0);
    push(1'b0);
    wait_on(2, 100);
    @(posedge pclk);
    bad <= 1'b1;
    wait_on(0, 300);
    chk("mute", n >= 90 && tq === 1'b1, 1'b1);
    @(posedge pclk);
    bad <= 1'b0;
    wait_on(2, 300);
    wr(OFS_CTRL, 32'h000003F9);
    wait_on(4, 1500);
    chk("pulse", act, 1'b0);
    chk("tbe", tbe, 1'b1);
    stop_test();
  end
endmodule
bind eso_sequencer eso_checker i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .estop_a_n, .torque_off,
  .emergency_active_output, .emergency_completed_output, .decel_request,
  .ctrl_stop_brake_enable, .torque_off_brake_enable);
`default_nettype wire
